// File: hw/irh_top.sv
// three-phase inrush detector with apb settings and interrupt
`timescale 1ns/100ps
`default_nettype none
`include "irh_cfg.svh"

// Summary of operation
// R01: Each phase supplies a fundamental and a second-harmonic magnitude as inputs.
// R02: A phase flag rises when its second harmonic over fundamental exceeds the ratio setting.
// R03: The ratio setting is a percent from 5 to 50 in steps of 1, resetting to 15.
// R04: A phase flag may rise only while its fundamental is above the sensitivity level.
// R05: The sensitivity setting is a percent from 20 to 100 in steps of 1, resetting to 30.
// R06: The sensitivity percent is taken relative to the ct nominal current.
// R07: Each phase is judged only from its own two magnitudes.
// R08: The general flag is the OR of the three phase flags.
// R09: While the block input is active all flags are held low.
// R10: Every change of the general flag raises an on or off event.
// R11: With operation off, the reset state, all flags stay low.
module irh_top (
  input  wire logic                   core_clk,         // 10 MHz clock
  input  wire logic                   srst,             // sync reset, high
  input  wire irh_pkg::irh_mag_t      fund_a,           // phase a fundamental
  input  wire irh_pkg::irh_mag_t      fund_b,           // phase b fundamental
  input  wire irh_pkg::irh_mag_t      fund_c,           // phase c fundamental
  input  wire irh_pkg::irh_mag_t      harm_a,           // phase a 2nd harmonic
  input  wire irh_pkg::irh_mag_t      harm_b,           // phase b 2nd harmonic
  input  wire irh_pkg::irh_mag_t      harm_c,           // phase c 2nd harmonic
  input  wire logic                   detect_block_in,  // user blocking input
  input  wire logic                   psel,             // apb select
  input  wire logic                   penable,          // apb enable
  input  wire logic                   pwrite,           // apb direction
  input  wire logic [`IRH_ADDR_W-1:0] paddr,            // apb byte address
  input  wire logic [31:0]            pwdata,           // apb write data
  output logic [31:0]                 prdata,           // apb read data
  output logic                        pready,           // apb ready
  output logic                        pslverr,          // apb error
  output logic                        inrush_phase_a_flag,   // phase a inrush
  output logic                        inrush_phase_b_flag,   // phase b inrush
  output logic                        inrush_phase_c_flag,   // phase c inrush
  output logic                        inrush_any_phase_flag, // general inrush
  output logic                        inrush_change_event,   // general flag toggled
  output logic                        irq                    // level interrupt
);
  // ---------------------------------------------------------------
  // settings and state
  // ---------------------------------------------------------------
  logic                  en_q;
  irh_pkg::irh_pct_t     ratio_q;
  irh_pkg::irh_pct_t     sens_q;
  irh_pkg::irh_mag_t     ctnom_q;
  logic [2:0]            ph_q;
  logic [2:0]            ph_d;
  logic                  any_q;
  logic                  any_d;
  logic                  event_q;
  logic [`IRH_INT_W-1:0] stat_q;
  logic [`IRH_INT_W-1:0] stat_d;
  logic [`IRH_INT_W-1:0] mask_q;
  logic [`IRH_INT_W-1:0] mask_d;
  logic                  irq_q;
  irh_pkg::irh_apb_e     apb_q;
  logic [31:0]           rdata_q;
  logic                  err_q;
  logic [2:0]            det;

  irh_pkg::irh_mag_t fund_v [3];
  irh_pkg::irh_mag_t harm_v [3];

  assign fund_v[0] = fund_a; // R01
  assign fund_v[1] = fund_b;
  assign fund_v[2] = fund_c;
  assign harm_v[0] = harm_a; // R01
  assign harm_v[1] = harm_b;
  assign harm_v[2] = harm_c;

  // ---------------------------------------------------------------
  // per-phase evaluation
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 3; i++) begin : g_ph
    // each instance sees only its own phase
    irh_phase_cmp u_cmp ( // R07
      .core_clk (core_clk),
      .srst     (srst),
      .fund     (fund_v[i]),
      .harm     (harm_v[i]),
      .ratio    (ratio_q),
      .sens     (sens_q),
      .ct_nom   (ctnom_q),
      .detect   (det[i])
    );
  end

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic access;
  logic fire;
  logic wr_fire;
  logic bad_wr;
  logic rd_hit;

  function automatic logic in_range(input logic [31:0] v,
                                    input irh_pkg::irh_pct_t lo,
                                    input irh_pkg::irh_pct_t hi);
    in_range = (v >= {25'h0, lo}) && (v <= {25'h0, hi});
  endfunction

  function automatic logic hit(input logic [`IRH_ADDR_W-1:0] a,
                               input logic [`IRH_ADDR_W-1:0] r);
    hit = (a == r);
  endfunction

  assign access  = psel & penable;
  // write lands only on the edge where ready is seen high
  assign fire    = access & (apb_q == irh_pkg::IRH_APB_RESP);
  assign wr_fire = fire & pwrite & ~err_q;

  always_comb begin
    bad_wr = 1'b0;
    if (hit(paddr, `IRH_REG_RATIO)) begin
      bad_wr = ~in_range(pwdata, `IRH_RATIO_MIN, `IRH_RATIO_MAX); // R03
    end else if (hit(paddr, `IRH_REG_SENS)) begin
      bad_wr = ~in_range(pwdata, `IRH_SENS_MIN, `IRH_SENS_MAX); // R05
    end else if (hit(paddr, `IRH_REG_FLAGS)) begin
      bad_wr = 1'b1;
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    unique case (paddr)
      `IRH_REG_CTRL, `IRH_REG_RATIO, `IRH_REG_SENS, `IRH_REG_CTNOM,
      `IRH_REG_FLAGS, `IRH_REG_INT_STAT, `IRH_REG_INT_MASK: rd_hit = 1'b1;
      default: rd_hit = 1'b0;
    endcase
  end

  // one wait state: data and error are staged on the same edge that raises ready
  always_ff @(posedge core_clk) begin
    if (srst) begin
      apb_q <= irh_pkg::IRH_APB_IDLE;
    end else begin
      unique case (apb_q)
        irh_pkg::IRH_APB_IDLE: if (access) apb_q <= irh_pkg::IRH_APB_RESP;
        irh_pkg::IRH_APB_RESP: apb_q <= irh_pkg::IRH_APB_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_q <= 32'h0;
      err_q   <= 1'b0;
    end else if (access & (apb_q == irh_pkg::IRH_APB_IDLE)) begin
      err_q   <= ~rd_hit | (pwrite & bad_wr);
      rdata_q <= 32'h0;
      if (~pwrite) begin
        unique case (paddr)
          `IRH_REG_CTRL:     rdata_q <= {31'h0, en_q};
          `IRH_REG_RATIO:    rdata_q <= {25'h0, ratio_q};
          `IRH_REG_SENS:     rdata_q <= {25'h0, sens_q};
          `IRH_REG_CTNOM:    rdata_q <= {16'h0, ctnom_q};
          `IRH_REG_FLAGS:    rdata_q <= {27'h0, detect_block_in, any_q, ph_q};
          `IRH_REG_INT_STAT: rdata_q <= {29'h0, stat_q};
          `IRH_REG_INT_MASK: rdata_q <= {29'h0, mask_q};
          default:           rdata_q <= 32'h0;
        endcase
      end
    end else begin
      rdata_q <= 32'h0;
      err_q   <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // settings registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      en_q    <= 1'b0; // R11
      ratio_q <= `IRH_RATIO_RST; // R03
      sens_q  <= `IRH_SENS_RST; // R05
      ctnom_q <= `IRH_CTNOM_RST;
    end else if (wr_fire) begin
      if (hit(paddr, `IRH_REG_CTRL)) en_q <= pwdata[`IRH_CTRL_EN_BIT];
      if (hit(paddr, `IRH_REG_RATIO)) ratio_q <= pwdata[`IRH_PCT_W-1:0]; // R03
      if (hit(paddr, `IRH_REG_SENS)) sens_q <= pwdata[`IRH_PCT_W-1:0]; // R05
      if (hit(paddr, `IRH_REG_CTNOM)) ctnom_q <= pwdata[`IRH_MAG_W-1:0]; // R06
    end
  end

  // ---------------------------------------------------------------
  // flags and change event
  // ---------------------------------------------------------------
  // block input comes from logic on this clock, so it is not synchronised
  assign ph_d  = (en_q & ~detect_block_in) ? det : 3'b000; // R09 R11
  assign any_d = |ph_d; // R08

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ph_q    <= 3'b000;
      any_q   <= 1'b0;
      event_q <= 1'b0;
    end else begin
      ph_q    <= ph_d; // R02 R04
      any_q   <= any_d; // R08
      event_q <= any_d ^ any_q; // R10
    end
  end

  // ---------------------------------------------------------------
  // interrupt status and mask
  // ---------------------------------------------------------------
  logic [`IRH_INT_W-1:0] ev_set;
  logic [`IRH_INT_W-1:0] ev_clr;

  assign ev_set[`IRH_INT_RISE_BIT] = any_d & ~any_q; // R10
  assign ev_set[`IRH_INT_FALL_BIT] = ~any_d & any_q; // R10
  assign ev_set[`IRH_INT_SET_BIT]  = fire & pwrite & err_q;

  assign ev_clr = (wr_fire && hit(paddr, `IRH_REG_INT_STAT)) ?
                  pwdata[`IRH_INT_W-1:0] : '0;

  // a new event wins over a clear in the same cycle
  assign stat_d = (stat_q & ~ev_clr) | ev_set;
  assign mask_d = (wr_fire && hit(paddr, `IRH_REG_INT_MASK)) ?
                  pwdata[`IRH_INT_W-1:0] : mask_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      stat_q <= '0;
      mask_q <= '0;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q  <= |(stat_d & mask_d);
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign inrush_phase_a_flag   = ph_q[0];
  assign inrush_phase_b_flag   = ph_q[1];
  assign inrush_phase_c_flag   = ph_q[2];
  assign inrush_any_phase_flag = any_q;
  assign inrush_change_event   = event_q;
  assign irq                   = irq_q;
  assign prdata                = rdata_q;
  assign pready                = (apb_q == irh_pkg::IRH_APB_RESP);
  assign pslverr               = err_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_setup;
    psel & ~penable;
  endsequence

  sequence s_wait;
    psel & penable & ~pready;
  endsequence

  a_apb_one_wait: assert property (
    s_setup ##1 s_wait |=> pready)
    else $error("ready not one cycle after access");
  a_block_clears: assert property ( // R09
    detect_block_in |=> !inrush_any_phase_flag && (ph_q == 3'b000))
    else $error("flag high during block");
  a_disable_clears: assert property ( // R11
    !en_q |=> (ph_q == 3'b000) && !any_q)
    else $error("flag high while operation off");
  a_any_is_or: assert property ( // R08
    inrush_any_phase_flag == (inrush_phase_a_flag | inrush_phase_b_flag
                              | inrush_phase_c_flag))
    else $error("general flag not the or of phases");
  a_event_on_change: assert property ( // R10
    $changed(any_q) |-> inrush_change_event)
    else $error("no event on general flag change");
  a_event_only_change: assert property ( // R10
    inrush_change_event |-> $changed(any_q) ##1 !inrush_change_event || $changed(any_q))
    else $error("spurious change event");
  a_ratio_range: assert property ( // R03
    ratio_q >= `IRH_RATIO_MIN && ratio_q <= `IRH_RATIO_MAX)
    else $error("ratio setting out of range");
  a_sens_range: assert property ( // R05
    sens_q >= `IRH_SENS_MIN && sens_q <= `IRH_SENS_MAX)
    else $error("sensitivity setting out of range");
  a_phase_cause: assert property ( // R07
    en_q && !detect_block_in |=> ph_q == $past(det))
    else $error("phase flag not from own detector");
  a_irq_level: assert property (
    irq == |(stat_q & mask_q))
    else $error("interrupt level mismatch");
  a_set_wins: assert property (
    ev_set[`IRH_INT_RISE_BIT] |=> stat_q[`IRH_INT_RISE_BIT])
    else $error("event lost against clear");

  // ---------------------------------------------------------------
  // bus and status checks
  // ---------------------------------------------------------------
  sequence s_wr_refused;
    fire & pwrite & err_q;
  endsequence

  sequence s_any_rise;
    !any_q ##1 any_q;
  endsequence

  sequence s_any_fall;
    any_q ##1 !any_q;
  endsequence

  // answer signals are only meaningful in the single ready cycle
  a_ready_one_cycle: assert property (
    pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_err_in_answer: assert property (
    pslverr |-> pready)
    else $error("error shown outside answer cycle");
  a_rdata_quiet: assert property (
    !pready |-> (prdata == 32'h0))
    else $error("read data outside answer cycle");
  a_ratio_written: assert property ( // R03
    wr_fire && hit(paddr, `IRH_REG_RATIO) |=> ratio_q == $past(pwdata[`IRH_PCT_W-1:0]))
    else $error("accepted ratio write not stored");
  a_sens_written: assert property ( // R05
    wr_fire && hit(paddr, `IRH_REG_SENS) |=> sens_q == $past(pwdata[`IRH_PCT_W-1:0]))
    else $error("accepted sensitivity write not stored");
  a_refused_keeps: assert property ( // R03 R05
    s_wr_refused |=> $stable(ratio_q) && $stable(sens_q) && $stable(en_q) && $stable(ctnom_q))
    else $error("refused write changed a setting");
  a_refused_flagged: assert property (
    s_wr_refused |=> stat_q[`IRH_INT_SET_BIT])
    else $error("refused write not recorded");
  a_rise_recorded: assert property ( // R10
    s_any_rise |-> inrush_change_event && stat_q[`IRH_INT_RISE_BIT])
    else $error("rise of general flag not recorded");
  a_fall_recorded: assert property ( // R10
    s_any_fall |-> inrush_change_event && stat_q[`IRH_INT_FALL_BIT])
    else $error("fall of general flag not recorded");
endmodule
`default_nettype wire

// File: hw/irh_cfg.svh
// constants of the inrush detector: register map, fields, resets, ranges
`ifndef IRH_CFG_SVH
`define IRH_CFG_SVH

`define IRH_MAG_W        16
`define IRH_PCT_W        7
`define IRH_ADDR_W       8

`define IRH_REG_CTRL     8'h00
`define IRH_REG_RATIO    8'h04
`define IRH_REG_SENS     8'h08
`define IRH_REG_CTNOM    8'h0c
`define IRH_REG_FLAGS    8'h10
`define IRH_REG_INT_STAT 8'h14
`define IRH_REG_INT_MASK 8'h18

`define IRH_CTRL_EN_BIT  0

`define IRH_FLAG_A_BIT   0
`define IRH_FLAG_B_BIT   1
`define IRH_FLAG_C_BIT   2
`define IRH_FLAG_ANY_BIT 3
`define IRH_FLAG_BLK_BIT 4

`define IRH_INT_W        3
`define IRH_INT_RISE_BIT 0
`define IRH_INT_FALL_BIT 1
`define IRH_INT_SET_BIT  2

`define IRH_RATIO_MIN    7'd5
`define IRH_RATIO_MAX    7'd50
`define IRH_RATIO_RST    7'd15
`define IRH_SENS_MIN     7'd20
`define IRH_SENS_MAX     7'd100
`define IRH_SENS_RST     7'd30
`define IRH_CTNOM_RST    16'h1000
`define IRH_PCT_FULL     7'd100

`endif

// File: hw/irh_pkg.sv
// types shared by the inrush detector modules
`include "irh_cfg.svh"
package irh_pkg;
  typedef logic [`IRH_MAG_W-1:0] irh_mag_t;
  typedef logic [`IRH_PCT_W-1:0] irh_pct_t;
  typedef logic [`IRH_MAG_W+`IRH_PCT_W-1:0] irh_prod_t;
  typedef enum logic {IRH_APB_IDLE, IRH_APB_RESP} irh_apb_e;
endpackage

// File: hw/irh_phase_cmp.sv
// one phase of the second-harmonic ratio test and fundamental gate
`timescale 1ns/100ps
`default_nettype none
`include "irh_cfg.svh"
module irh_phase_cmp (
  input  wire logic             core_clk,  // evaluation clock
  input  wire logic             srst,      // sync reset
  input  wire irh_pkg::irh_mag_t fund,     // fundamental magnitude
  input  wire irh_pkg::irh_mag_t harm,     // second harmonic magnitude
  input  wire irh_pkg::irh_pct_t ratio,    // ratio setting, percent
  input  wire irh_pkg::irh_pct_t sens,     // sensitivity, percent of ct nominal
  input  wire irh_pkg::irh_mag_t ct_nom,   // ct nominal in magnitude units
  output logic                  detect     // raw inrush decision
);
  function automatic irh_pkg::irh_prod_t pct_of(input irh_pkg::irh_mag_t m,
                                                input irh_pkg::irh_pct_t p);
    pct_of = irh_pkg::irh_prod_t'(m) * irh_pkg::irh_prod_t'(p);
  endfunction

  logic ratio_hit;
  logic fund_ok;

  // cross-multiplied, so no divider and no rounding of the ratio
  assign ratio_hit = pct_of(harm, `IRH_PCT_FULL) > pct_of(fund, ratio); // R02
  assign fund_ok   = pct_of(fund, `IRH_PCT_FULL) > pct_of(ct_nom, sens); // R04 R06
  assign detect    = ratio_hit & fund_ok; // R04

  a_gate_fund: assert property (@(posedge core_clk) disable iff (srst) // R04
    detect |-> (fund * 100 > ct_nom * sens))
    else $error("detect without enough fundamental");
  a_ratio_test: assert property (@(posedge core_clk) disable iff (srst) // R02
    (fund * 100 > ct_nom * sens) && (harm * 100 > fund * ratio) |-> detect)
    else $error("ratio exceeded but no detect");
endmodule
`default_nettype wire

// File: dv/irh_src_model.sv
// upstream magnitude source and user blocking logic for the inrush detector
`timescale 1ns/100ps
`default_nettype none
module irh_src_model (
  input  wire logic             core_clk,        // evaluation clock
  output var irh_pkg::irh_mag_t fund_a,          // phase a fundamental
  output var irh_pkg::irh_mag_t fund_b,          // phase b fundamental
  output var irh_pkg::irh_mag_t fund_c,          // phase c fundamental
  output var irh_pkg::irh_mag_t harm_a,          // phase a 2nd harmonic
  output var irh_pkg::irh_mag_t harm_b,          // phase b 2nd harmonic
  output var irh_pkg::irh_mag_t harm_c,          // phase c 2nd harmonic
  output var logic              detect_block_in  // user blocking equation
);
  // ----------------------------------------
  // measurement and blocking drivers
  // ----------------------------------------
  initial begin
    {fund_a, fund_b, fund_c, harm_a, harm_b, harm_c} = '0;
    detect_block_in = 1'b0;
  end

  // all six magnitudes move on one edge, like a fourier output register
  task automatic set_all(input irh_pkg::irh_mag_t fa, ha, fb, hb, fc, hc);
    @(posedge core_clk);
    fund_a <= fa;
    harm_a <= ha;
    fund_b <= fb;
    harm_b <= hb;
    fund_c <= fc;
    harm_c <= hc;
  endtask

  task automatic set_blk(input logic b);
    @(posedge core_clk);
    detect_block_in <= b;
  endtask
endmodule
`default_nettype wire

// File: dv/irh_top_tb.sv
// self-checking bench for the three-phase inrush detector
`timescale 1ns/100ps
`default_nettype none
`include "irh_cfg.svh"
module irh_top_tb;
  logic                   core_clk = 1'b0;
  logic                   srst = 1'b1;
  logic                   psel = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite = 1'b0;
  logic [`IRH_ADDR_W-1:0] paddr = '0;
  logic [31:0]            pwdata = 32'h0;
  logic [31:0]            prdata;
  logic                   pready, pslverr, irq, ev, blk;
  logic [3:0]             fl;
  irh_pkg::irh_mag_t      fund_a, fund_b, fund_c, harm_a, harm_b, harm_c;
  int                     error_cnt = 0;
  int                     check_count = 0;
  int                     ev_cnt = 0;
  logic                   en_v = 1'b0;
  int                     ct_v = 32'h1000;
  int                     ratio_v = 32'h0f;
  int                     sens_v = 32'h1e;

  irh_src_model src_u (.core_clk(core_clk), .fund_a(fund_a), .fund_b(fund_b),
    .fund_c(fund_c), .harm_a(harm_a), .harm_b(harm_b), .harm_c(harm_c),
    .detect_block_in(blk));

  irh_top dut_u (.core_clk(core_clk), .srst(srst), .fund_a(fund_a), .fund_b(fund_b),
    .fund_c(fund_c), .harm_a(harm_a), .harm_b(harm_b), .harm_c(harm_c),
    .detect_block_in(blk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .inrush_phase_a_flag(fl[0]), .inrush_phase_b_flag(fl[1]),
    .inrush_phase_c_flag(fl[2]), .inrush_any_phase_flag(fl[3]),
    .inrush_change_event(ev), .irq(irq));

  always #50 core_clk = ~core_clk;

  // a pulse longer than one cycle would be counted twice
  always @(posedge core_clk) if (ev === 1'b1) ev_cnt <= ev_cnt + 1;

  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic det(input irh_pkg::irh_mag_t f, h);
    return (h * 32'h64 > f * ratio_v) && (f * 32'h64 > ct_v * sens_v);
  endfunction

  function automatic logic [3:0] exp_f();
    logic on, a, b, c;
    on = en_v && !blk;
    a = on && det(fund_a, harm_a);
    b = on && det(fund_b, harm_b);
    c = on && det(fund_c, harm_c);
    return {a | b | c, c, b, a};
  endfunction

  task automatic fchk();
    chk("flags", {28'h0, fl}, {28'h0, exp_f()});
  endtask

  task automatic settle();
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  // one apb transfer; a slave that never answers is left to the watchdog
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] ed, input logic ee);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    chk("pslverr", {31'h0, pslverr}, {31'h0, ee});
    if (!wr) chk("prdata", prdata, ed);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    src_u.set_all(16'h190, 16'h3d, 16'h12c, 16'hc8, 16'h12d, 16'hc8);
    settle();
    fchk();
    xfer(1'b0, `IRH_REG_CTRL, 32'h0, 32'h0, 1'b0);
    xfer(1'b0, `IRH_REG_RATIO, 32'h0, 32'h0f, 1'b0);
    xfer(1'b0, `IRH_REG_SENS, 32'h0, 32'h1e, 1'b0);
    xfer(1'b0, `IRH_REG_INT_STAT, 32'h0, 32'h0, 1'b0);
    chk("irq", {31'h0, irq}, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_limits();
    logic [7:0] a;
    logic [31:0] lo, hi;
    for (int i = 0; i < 2; i++) begin
      a = i ? `IRH_REG_SENS : `IRH_REG_RATIO;
      lo = i ? 32'h14 : 32'h05;
      hi = i ? 32'h64 : 32'h32;
      xfer(1'b1, a, lo, 32'h0, 1'b0);
      xfer(1'b0, a, 32'h0, lo, 1'b0);
      xfer(1'b1, a, hi, 32'h0, 1'b0);
      xfer(1'b1, a, hi + 1, 32'h0, 1'b1);
      xfer(1'b1, a, lo - 1, 32'h0, 1'b1);
      xfer(1'b1, a, lo | 32'h8000_0000, 32'h0, 1'b1);
      xfer(1'b0, a, 32'h0, hi, 1'b0);
    end
    xfer(1'b1, 8'h1c, 32'h1, 32'h0, 1'b1);
    xfer(1'b0, 8'h1c, 32'h0, 32'h0, 1'b1);
    xfer(1'b1, `IRH_REG_FLAGS, 32'h1, 32'h0, 1'b1);
    xfer(1'b0, `IRH_REG_INT_STAT, 32'h0, 32'h4, 1'b0);
    xfer(1'b1, `IRH_REG_INT_STAT, 32'h4, 32'h0, 1'b0);
    xfer(1'b0, `IRH_REG_INT_STAT, 32'h0, 32'h0, 1'b0);
    $display("test limits done");
  endtask

  task automatic t_detect();
    ratio_v = 32'h0f;
    sens_v = 32'h1e;
    ct_v = 32'h3e8;
    xfer(1'b1, `IRH_REG_RATIO, ratio_v, 32'h0, 1'b0);
    xfer(1'b1, `IRH_REG_SENS, sens_v, 32'h0, 1'b0);
    xfer(1'b1, `IRH_REG_CTNOM, ct_v, 32'h0, 1'b0);
    xfer(1'b1, `IRH_REG_INT_MASK, 32'h1, 32'h0, 1'b0);
    en_v = 1'b1;
    xfer(1'b1, `IRH_REG_CTRL, 32'h1, 32'h0, 1'b0);
    settle();
    // b sits exactly on the sensitivity level, so only a and c may rise
    chk("flags", {28'h0, fl}, 32'hd);
    fchk();
    chk("events", ev_cnt, 32'h1);
    chk("irq", {31'h0, irq}, 32'h1);
    xfer(1'b0, `IRH_REG_FLAGS, 32'h0, 32'hd, 1'b0);
    src_u.set_all(16'h190, 16'h3c, 16'h12c, 16'hc8, 16'h12d, 16'hc8);
    settle();
    fchk();
    chk("events", ev_cnt, 32'h1);
    $display("test detect done");
  endtask

  task automatic t_block();
    src_u.set_blk(1'b1);
    settle();
    fchk();
    chk("events", ev_cnt, 32'h2);
    xfer(1'b0, `IRH_REG_INT_STAT, 32'h0, 32'h3, 1'b0);
    xfer(1'b1, `IRH_REG_INT_STAT, 32'h1, 32'h0, 1'b0);
    settle();
    chk("irq", {31'h0, irq}, 32'h0);
    xfer(1'b1, `IRH_REG_INT_MASK, 32'h3, 32'h0, 1'b0);
    settle();
    chk("irq", {31'h0, irq}, 32'h1);
    xfer(1'b1, `IRH_REG_INT_STAT, 32'h2, 32'h0, 1'b0);
    xfer(1'b0, `IRH_REG_FLAGS, 32'h0, 32'h10, 1'b0);
    src_u.set_blk(1'b0);
    settle();
    fchk();
    chk("events", ev_cnt, 32'h3);
    en_v = 1'b0;
    xfer(1'b1, `IRH_REG_CTRL, 32'h0, 32'h0, 1'b0);
    settle();
    fchk();
    chk("events", ev_cnt, 32'h4);
    $display("test block done");
  endtask

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    error_cnt++;
    wrap_up();
  end

  initial begin
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    t_reset();
    t_limits();
    t_detect();
    t_block();
    wrap_up();
  end
endmodule
`default_nettype wire
